// >>> rss_pkg.sv
// Package for the reset source sequencer: constants, types and register layout
`default_nettype none

package rss_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [5:0] RSS_STATUS_ADDR = 6'h34;
  localparam int RSS_WDT_BIT = 3;
  localparam int RSS_BOR_BIT = 2;
  localparam int RSS_EXT_BIT = 1;
  localparam int RSS_POR_BIT = 0;
  localparam logic [3:0] RSS_STATUS_RST = 4'h1;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int RSS_CLK_HZ = 20000000;
  localparam int RSS_RC_HZ = 1000000;
  localparam int RSS_PIN_MIN_CYC = 2;
  localparam int RSS_SHORT_MS = 4;
  localparam int RSS_LONG_MS = 64;
  localparam int RSS_CK_A = 6;
  localparam int RSS_CK_B = 1024;
  localparam int RSS_CK_C = 16384;
  localparam int RSS_SHORT_RC = RSS_RC_HZ / 1000 * RSS_SHORT_MS;
  localparam int RSS_LONG_RC = RSS_RC_HZ / 1000 * RSS_LONG_MS;
  localparam logic [2:0] RSS_SEL_RST = 3'h2;
  localparam logic [15:0] RSS_VECTOR_ADDR = 16'h0000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    RSS_ST_HOLD = 3'h1,
    RSS_ST_RC = 3'h2,
    RSS_ST_RUN = 3'h4
  } rss_state_e;

  typedef struct packed
  {
    logic powerup;
    logic brownout;
    logic pin_low;
    logic watchdog;
  } rss_src_s;

  typedef struct packed
  {
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rss_io_s;

endpackage : rss_pkg

`default_nettype wire

// >>> rss_top.sv
// Reset source sequencer: combines reset sources, times release, keeps cause flags
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`default_nettype none

module rss_top #(
  parameter int RC_DIV = rss_pkg::RSS_CLK_HZ / rss_pkg::RSS_RC_HZ,
  parameter int SHORT_RC = rss_pkg::RSS_SHORT_RC,
  parameter int LONG_RC = rss_pkg::RSS_LONG_RC,
  parameter int CK_C = rss_pkg::RSS_CK_C
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic RESET_PIN_N,
  input wire logic POWER_LOW,
  input wire logic BROWNOUT_DETECT,
  input wire logic BROWNOUT_ENABLE_FUSE,
  input wire logic [2:0] STARTUP_DELAY_SELECT,
  input wire logic WDT_ENABLE,
  input wire logic WDT_EXPIRE,
  input wire rss_pkg::rss_io_s IO_REQ,
  output logic [7:0] IO_RDATA,
  output logic CORE_RESET,
  output logic IO_INIT,
  output logic [15:0] START_ADDR
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic [1:0] pin_sync;
    logic [1:0] pwr_sync;
    logic [1:0] bod_sync;
    logic [1:0] pin_low_cnt;
    logic wdt_pulse;
    logic wdt_prev;
    rss_pkg::rss_state_e state;
    logic [2:0] sel;
    logic [19:0] rc_cnt;
    logic [15:0] ck_cnt;
    logic [7:0] div_cnt;
    logic [3:0] flags;
    logic core_rst;
    logic [7:0] rdata;
    logic [21:0] rc_cyc;
  } rss_st_s;

  rss_st_s s_q;
  rss_st_s s_d;
  rss_pkg::rss_src_s src;
  logic pin_low;
  logic bod_low;
  logic pwr_low;
  logic [19:0] rc_need;
  logic [15:0] ck_need;
  logic rc_tick;
  logic [21:0] rc_lo;
  logic [21:0] rc_hi;

  assign pin_low = s_q.pin_sync[1] == 1'b0;
  assign pwr_low = s_q.pwr_sync[1];
  assign bod_low = s_q.bod_sync[1] & BROWNOUT_ENABLE_FUSE;

  // ------------------------------------------------------------------
  // Delay selection
  // ------------------------------------------------------------------
  always_comb
  begin
    rc_need = 20'h00000;
    ck_need = 16'h0000;
    case (s_q.sel)
      3'h0:
      begin
        rc_need = 20'(SHORT_RC);
        ck_need = 16'(rss_pkg::RSS_CK_A);
      end
      3'h1: ck_need = 16'(rss_pkg::RSS_CK_A);
      3'h2:
      begin
        rc_need = 20'(LONG_RC);
        ck_need = 16'(CK_C);
      end
      3'h3:
      begin
        rc_need = 20'(SHORT_RC);
        ck_need = 16'(CK_C);
      end
      3'h4: ck_need = 16'(CK_C);
      3'h5:
      begin
        rc_need = 20'(LONG_RC);
        ck_need = 16'(rss_pkg::RSS_CK_B);
      end
      3'h6:
      begin
        rc_need = 20'(SHORT_RC);
        ck_need = 16'(rss_pkg::RSS_CK_B);
      end
      default: ck_need = 16'(rss_pkg::RSS_CK_B);
    endcase
  end

  assign rc_tick = s_q.div_cnt == 8'(RC_DIV - 1);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.pin_sync = {s_q.pin_sync[0], RESET_PIN_N};
    s_d.pwr_sync = {s_q.pwr_sync[0], POWER_LOW};
    s_d.bod_sync = {s_q.bod_sync[0], BROWNOUT_DETECT};
    s_d.div_cnt = rc_tick ? 8'h00 : s_q.div_cnt + 8'h01;
    // Cycles spent counting, read only by the delay checks
    s_d.rc_cyc = (s_q.state == rss_pkg::RSS_ST_RC) ? s_q.rc_cyc + 22'h000001 : 22'h000000;

    // Filter needs the pin low for more than two clocks
    if (!pin_low)
      s_d.pin_low_cnt = 2'h0;
    else if (s_q.pin_low_cnt != 2'h3)
      s_d.pin_low_cnt = s_q.pin_low_cnt + 2'h1;

    // One-clock internal pulse from an enabled expiry
    s_d.wdt_pulse = WDT_EXPIRE & WDT_ENABLE & ~s_q.wdt_pulse;
    s_d.wdt_prev = s_q.wdt_pulse;

    src.powerup = pwr_low;
    src.brownout = bod_low;
    src.pin_low = s_q.pin_low_cnt > 2'(rss_pkg::RSS_PIN_MIN_CYC);
    src.watchdog = s_q.wdt_pulse;

    case (s_q.state)
      rss_pkg::RSS_ST_HOLD:
      begin
        // Counter idle while any source persists; starts after the last one ends
        if (!(src.powerup | src.brownout | src.pin_low | src.watchdog))
        begin
          s_d.sel = STARTUP_DELAY_SELECT;
          s_d.rc_cnt = 20'h00000;
          s_d.ck_cnt = 16'h0000;
          s_d.state = rss_pkg::RSS_ST_RC;
        end
      end
      rss_pkg::RSS_ST_RC:
      begin
        if (s_q.rc_cnt < rc_need)
        begin
          if (rc_tick)
            s_d.rc_cnt = s_q.rc_cnt + 20'h00001;
        end
        else if (s_q.ck_cnt < ck_need - 16'h0001)
          s_d.ck_cnt = s_q.ck_cnt + 16'h0001;
        else
          s_d.state = rss_pkg::RSS_ST_RUN;
      end
      rss_pkg::RSS_ST_RUN: ;
      default: s_d.state = rss_pkg::RSS_ST_HOLD;
    endcase

    // Any source restarts the sequence immediately
    if (src.powerup | src.brownout | src.pin_low | src.watchdog)
      s_d.state = rss_pkg::RSS_ST_HOLD;

    s_d.core_rst = s_d.state != rss_pkg::RSS_ST_RUN;

    // Software writes zero to clear; a same-cycle event wins
    if (IO_REQ.we && IO_REQ.addr == rss_pkg::RSS_STATUS_ADDR)
      s_d.flags = s_q.flags & IO_REQ.wdata[3:0];
    if (src.powerup)
      s_d.flags = 4'h1;
    if (src.brownout)
      s_d.flags[rss_pkg::RSS_BOR_BIT] = 1'b1;
    if (src.pin_low)
      s_d.flags[rss_pkg::RSS_EXT_BIT] = 1'b1;
    if (src.watchdog)
      s_d.flags[rss_pkg::RSS_WDT_BIT] = 1'b1;

    s_d.rdata = (IO_REQ.addr == rss_pkg::RSS_STATUS_ADDR) ? {4'h0, s_q.flags} : 8'h00;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_q <= '0;
      s_q.pin_sync <= 2'h3;
      s_q.state <= rss_pkg::RSS_ST_HOLD;
      s_q.sel <= rss_pkg::RSS_SEL_RST;
      s_q.flags <= rss_pkg::RSS_STATUS_RST;
      s_q.core_rst <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign IO_RDATA = s_q.rdata;
  assign CORE_RESET = s_q.core_rst;
  assign IO_INIT = s_q.core_rst;
  assign START_ADDR = rss_pkg::RSS_VECTOR_ADDR;

  // ------------------------------------------------------------------
  // Check helpers
  // ------------------------------------------------------------------
  // Legal release window; the RC divider phase gives one period of slack
  always_comb
  begin
    rc_hi = 22'(ck_need) + 22'(rc_need) * 22'(RC_DIV);
    if (rc_need == 20'h00000)
      rc_lo = 22'(ck_need);
    else
      rc_lo = 22'(ck_need) + (22'(rc_need) - 22'h000001) * 22'(RC_DIV);
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  AST_PIN_FILTER: assert property ($rose(src.pin_low) |-> $past(pin_low, 3))
    else $error("pin reset taken without three low cycles");
  AST_WDT_ENABLED: assert property ($rose(s_q.wdt_pulse) |-> $past(WDT_ENABLE))
    else $error("watchdog pulse while disabled");
  AST_WDT_ONE: assert property (s_q.wdt_pulse |=> !s_q.wdt_pulse)
    else $error("watchdog pulse longer than one cycle");
  AST_WDT_HOLD: assert property (s_q.wdt_pulse |=> ##1 CORE_RESET)
    else $error("core released right after watchdog pulse");
  AST_POWER_IMMED: assert property (pwr_low |=> CORE_RESET)
    else $error("power low did not reset core");
  AST_BOD_IMMED: assert property (bod_low |=> CORE_RESET && s_q.flags[2])
    else $error("brown-out did not reset core");
  AST_UPPER_ZERO: assert property (IO_RDATA[7:4] == 4'h0)
    else $error("status upper bits not zero");
  AST_POR_FLAGS: assert property (pwr_low |=> s_q.flags[0] && !s_q.flags[3])
    else $error("power-up flag handling wrong");
  AST_MIN_DELAY: assert property ($fell(CORE_RESET) |-> $past(s_q.state, 6) == rss_pkg::RSS_ST_RC)
    else $error("core released before minimum delay");
  AST_RUN_OR: assert property ((s_q.state == rss_pkg::RSS_ST_RUN) |-> !CORE_RESET)
    else $error("core reset not matching sequencer state");

  // ------------------------------------------------------------------
  // Delay, source and output checks
  // ------------------------------------------------------------------
  AST_DELAY_SPAN: assert property ($fell(CORE_RESET) |-> s_q.rc_cyc >= rc_lo && s_q.rc_cyc <= rc_hi)
    else $error("release delay outside selected window");
  AST_SRC_HOLD: assert property ((pwr_low || bod_low || src.pin_low || s_q.wdt_pulse) |=>
    CORE_RESET && s_q.state == rss_pkg::RSS_ST_HOLD)
    else $error("active source did not hold core in reset");
  AST_WDT_START: assert property ((s_q.wdt_prev && !s_q.wdt_pulse && !pwr_low && !bod_low && !src.pin_low) |=>
    s_q.state == rss_pkg::RSS_ST_RC)
    else $error("delay did not start at watchdog pulse end");
  AST_IO_INIT: assert property (IO_INIT == CORE_RESET)
    else $error("io init does not follow core reset");
  AST_START_ZERO: assert property (START_ADDR == rss_pkg::RSS_VECTOR_ADDR)
    else $error("start address not zero");

  // ------------------------------------------------------------------
  // Flag checks
  // ------------------------------------------------------------------
  AST_PIN_FLAG: assert property (src.pin_low |=> s_q.flags[1] && CORE_RESET)
    else $error("pin reset did not set its flag");
  AST_WDT_FLAG: assert property (s_q.wdt_pulse |=> s_q.flags[3])
    else $error("watchdog reset did not set its flag");
  AST_POR_CLEAR: assert property ((pwr_low && !bod_low && !src.pin_low && !s_q.wdt_pulse) |=>
    s_q.flags[3:1] == 3'h0)
    else $error("power-up did not clear other flags");
  AST_NO_WRITE_SET: assert property ((!pwr_low && !bod_low && !src.pin_low && !s_q.wdt_pulse) |=>
    (s_q.flags & ~$past(s_q.flags)) == 4'h0)
    else $error("flag set without a reset event");
  AST_ZERO_CLEAR: assert property ((IO_REQ.we && IO_REQ.addr == rss_pkg::RSS_STATUS_ADDR && !IO_REQ.wdata[0]
    && !pwr_low) |=> !s_q.flags[0])
    else $error("zero write did not clear power-up flag");
  AST_SET_WINS: assert property ((IO_REQ.we && IO_REQ.addr == rss_pkg::RSS_STATUS_ADDR && src.pin_low) |=>
    s_q.flags[1])
    else $error("clear beat a same-cycle pin event");
  AST_RDATA: assert property ((IO_REQ.addr == rss_pkg::RSS_STATUS_ADDR) |=>
    IO_RDATA == {4'h0, $past(s_q.flags)})
    else $error("status read data wrong");

  COV_POWERUP: cover property ($fell(CORE_RESET));
  COV_PIN: cover property ($rose(src.pin_low));
  COV_WDT: cover property (s_q.wdt_pulse ##1 CORE_RESET);
  COV_BOD: cover property (bod_low);
  COV_CLEAR: cover property (IO_REQ.we && IO_REQ.addr == rss_pkg::RSS_STATUS_ADDR);

endmodule : rss_top

`default_nettype wire

// >>> rss_partner.sv
// Far-side model: external reset driver and supply detectors
`default_nettype none
module rss_partner
(
  input wire logic clk,
  input wire logic pin_go,
  input wire logic [7:0] pin_cyc,
  input wire logic pwr_lo,
  input wire logic bod_lo,
  output logic pin_n,
  output logic power_low,
  output logic brownout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q = 8'h00;
  // Driver holds the pin low for the commanded count
  always @(posedge clk)
  begin
    if (pin_go)
      left_q <= pin_cyc;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // Pin has a pull-up: high whenever not driven
  assign pin_n = (left_q == 8'h00);
  assign power_low = pwr_lo;
  assign brownout = bod_lo;
endmodule : rss_partner
`default_nettype wire

// >>> rss_top_bench.sv
// Self-checking testbench for the reset source sequencer
`default_nettype none
module rss_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RCD = 2;
  localparam int SRC = 4;
  localparam int LRC = 8;
  localparam int CKC = 32;
  logic clk_sys = 0, rst_n = 0, wdt_en = 0, wdt_exp = 0, fuse = 0, pwr_lo = 1, bod_lo = 0, pin_go = 0;
  logic [2:0] sel = 3'h1;
  logic [7:0] pin_cyc = 8'h00;
  logic [7:0] rdata;
  logic [15:0] start_addr;
  logic core_rst, io_init, pin_n, pwr_low, brownout_detect;
  rss_pkg::rss_io_s io_req = '0;
  int err_count = 0, samples_checked = 0;
  always #25 clk_sys = ~clk_sys;
  rss_partner far (.clk(clk_sys), .pin_go(pin_go), .pin_cyc(pin_cyc), .pwr_lo(pwr_lo), .bod_lo(bod_lo),
    .pin_n(pin_n), .power_low(pwr_low), .brownout(brownout_detect));
  rss_top #(.RC_DIV(RCD), .SHORT_RC(SRC), .LONG_RC(LRC), .CK_C(CKC)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .RESET_PIN_N(pin_n), .POWER_LOW(pwr_low), .BROWNOUT_DETECT(brownout_detect), .BROWNOUT_ENABLE_FUSE(fuse),
    .STARTUP_DELAY_SELECT(sel), .WDT_ENABLE(wdt_en), .WDT_EXPIRE(wdt_exp), .IO_REQ(io_req),
    .IO_RDATA(rdata), .CORE_RESET(core_rst), .IO_INIT(io_init), .START_ADDR(start_addr));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkr(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: delay %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask : chkr
  function automatic int tout(input logic [2:0] s);
    int ck[8] = '{6, 6, CKC, CKC, CKC, 1024, 1024, 1024};
    int rc[8] = '{SRC, 0, LRC, SRC, 0, LRC, SRC, 0};
    return ck[s] + rc[s] * RCD;
  endfunction : tout
  task automatic rd(input logic [7:0] exp);
    @(posedge clk_sys);
    io_req <= '{1'b0, rss_pkg::RSS_STATUS_ADDR, 8'h00};
    @(posedge clk_sys);
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_req <= '{1'b1, a, d};
    @(posedge clk_sys);
    io_req <= '{1'b0, a, d};
  endtask : wr
  // Waits for reset to rise, then counts cycles until release
  task automatic rel(input int t);
    int n;
    n = 0;
    while (core_rst !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    n = 0;
    while (core_rst !== 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    chkr(n, t, t + 16);
  endtask : rel
  task automatic pulse(input int what, input logic [7:0] cyc);
    @(posedge clk_sys);
    if (what == 0)
      pin_cyc <= cyc;
    pin_go <= (what == 0);
    wdt_exp <= (what == 1);
    @(posedge clk_sys);
    pin_go <= 1'b0;
    wdt_exp <= 1'b0;
  endtask : pulse
  task automatic pwr_cycle(input logic [2:0] s);
    @(posedge clk_sys);
    sel <= s;
    pwr_lo <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 chk(16'(core_rst), 16'h0001);
    @(posedge clk_sys);
    pwr_lo <= 1'b0;
    rel(tout(s));
  endtask : pwr_cycle
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk(start_addr, rss_pkg::RSS_VECTOR_ADDR);
    chk(16'(io_init), 16'h0001);
    for (int s = 0; s < 8; s++)
    begin
      pwr_cycle(3'(s));
      rd(8'h01);
    end
    wr(6'h34, 8'hFF);
    rd(8'h01);
    wr(6'h33, 8'h00);
    rd(8'h01);
    wr(6'h34, 8'hFE);
    rd(8'h00);
    pulse(0, 8'h02);
    repeat (10) @(posedge clk_sys);
    #1 chk(16'(core_rst), 16'h0000);
    pulse(0, 8'h06);
    rel(tout(sel));
    rd(8'h02);
    pulse(1, 8'h00);
    repeat (6) @(posedge clk_sys);
    #1 chk(16'(core_rst), 16'h0000);
    @(posedge clk_sys);
    wdt_en <= 1'b1;
    pulse(1, 8'h00);
    rel(tout(sel));
    rd(8'h0A);
    @(posedge clk_sys);
    bod_lo <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 chk(16'(core_rst), 16'h0000);
    @(posedge clk_sys);
    fuse <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk(16'(core_rst), 16'h0001);
    @(posedge clk_sys);
    bod_lo <= 1'b0;
    rel(tout(sel));
    rd(8'h0E);
    pwr_cycle(3'h1);
    rd(8'h01);
    results();
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    results();
  end
endmodule : rss_top_bench
`default_nettype wire
